// >>> rtl/uhp_pkg.sv
// Package of constants for the host pipe interrupt enable block
package uhp_pkg;
    // ****************************************
    // Bus widths
    // ****************************************
    localparam int UHP_AW = 12;
    localparam int UHP_DW = 32;
    // ****************************************
    // Register indices, byte address is four times the index
    // ****************************************
    localparam logic [9:0] UHP_IDX_EN_CLR = 10'h108;
    localparam logic [9:0] UHP_IDX_EN_SET = 10'h109;
    localparam logic [9:0] UHP_IDX_BASE = 10'h120;
    localparam logic [9:0] UHP_IDX_FETCH = 10'h121;
    localparam logic [9:0] UHP_IDX_PTR = 10'h122;
    localparam logic [9:0] UHP_IDX_PCK = 10'h123;
    localparam logic [9:0] UHP_IDX_SIZE = 10'h124;
    localparam logic [9:0] UHP_IDX_EVT = 10'h125;
    localparam logic [9:0] UHP_IDX_MASK = 10'h126;
    localparam logic [11:0] UHP_ADR_EN_CLR = {UHP_IDX_EN_CLR, 2'h0};
    localparam logic [11:0] UHP_ADR_EN_SET = {UHP_IDX_EN_SET, 2'h0};
    localparam logic [11:0] UHP_ADR_BASE = {UHP_IDX_BASE, 2'h0};
    localparam logic [11:0] UHP_ADR_FETCH = {UHP_IDX_FETCH, 2'h0};
    localparam logic [11:0] UHP_ADR_PTR = {UHP_IDX_PTR, 2'h0};
    localparam logic [11:0] UHP_ADR_PCK = {UHP_IDX_PCK, 2'h0};
    localparam logic [11:0] UHP_ADR_SIZE = {UHP_IDX_SIZE, 2'h0};
    localparam logic [11:0] UHP_ADR_EVT = {UHP_IDX_EVT, 2'h0};
    localparam logic [11:0] UHP_ADR_MASK = {UHP_IDX_MASK, 2'h0};
    // ****************************************
    // Enable bit positions and layout
    // ****************************************
    localparam int UHP_B_STALL = 5;
    localparam int UHP_B_SETUP = 4;
    localparam int UHP_B_PIPE_ERROR = 3;
    localparam int UHP_B_TRANSFER_FAIL = 2;
    localparam int UHP_B_TRANSFER_COMPLETE = 0;
    localparam logic [7:0] UHP_EN_MASK = 8'h3d;
    localparam logic [7:0] UHP_EN_RST = 8'h00;
    // ****************************************
    // Descriptor offsets in system RAM, bytes
    // ****************************************
    localparam logic [31:0] UHP_DOFS_PTR0 = 32'h00000000;
    localparam logic [31:0] UHP_DOFS_PCK0 = 32'h00000004;
    localparam logic [31:0] UHP_DOFS_PTR1 = 32'h00000010;
    localparam logic [31:0] UHP_DOFS_PCK1 = 32'h00000014;
    localparam logic [31:0] UHP_ALIGN_MASK = 32'h00000003;
    // ****************************************
    // Packet size word fields
    // ****************************************
    localparam int UHP_F_AZLP = 31;
    localparam int UHP_F_SIZE_HI = 30;
    localparam int UHP_F_SIZE_LO = 28;
    localparam logic [2:0] UHP_SZ_CODE_MAX = 3'h7;
    localparam logic [10:0] UHP_SZ_BASE = 11'h008;
    localparam logic [10:0] UHP_SZ_FS_MAX = 11'h3ff;
    // ****************************************
    // Event status bits
    // ****************************************
    localparam int UHP_EV_DONE = 0;
    localparam int UHP_EV_ALIGN = 1;
    localparam int UHP_EV_W = 2;
endpackage

// >>> rtl/uhp_desc_fetch.sv
// Descriptor word fetcher for one pipe bank
`timescale 1ns/1ps
`default_nettype none
module uhp_desc_fetch
    import uhp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic go,
    input wire logic bank,
    input wire logic [31:0] base,
    output logic [31:0] ram_addr,
    output logic ram_rd,
    input wire logic [31:0] ram_rdata,
    output logic [31:0] buf_ptr,
    output logic [31:0] pck_word,
    output logic [10:0] size_bytes,
    output logic done,
    output logic misaligned
);
    // ****************************************
    // State
    // ****************************************
    typedef enum logic [1:0] {FS_IDLE, FS_PTR, FS_PCK, FS_FIN} uhp_fst_t;
    typedef struct packed {
        uhp_fst_t st;      // Sequencer state
        logic bank;        // Latched bank
        logic [31:0] base; // Latched descriptor base
        logic [31:0] addr; // RAM address
        logic rd;          // RAM read strobe
        logic [31:0] ptr;  // Buffer pointer word
        logic [31:0] pck;  // Packet size word
        logic [10:0] sz;   // Decoded pipe size
        logic done;        // Fetch done pulse
        logic mis;         // Misaligned pointer pulse
    } uhp_fetch_t;
    uhp_fetch_t q, d;
    // Code 7 is the full-speed ceiling, the rest are powers of two
    function automatic logic [10:0] sz_dec(input logic [2:0] c);
        sz_dec = (c == UHP_SZ_CODE_MAX) ? UHP_SZ_FS_MAX : (UHP_SZ_BASE << c);
    endfunction
    // Pipelined reads: the second address goes out while the first word returns
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.mis = 1'b0;
        d.rd = 1'b0;
        case (q.st)
            FS_IDLE: begin
                // A go while busy is ignored
                if (go) begin
                    d.bank = bank;
                    d.base = base;
                    d.addr = base + (bank ? UHP_DOFS_PTR1 : UHP_DOFS_PTR0);
                    d.rd = 1'b1;
                    d.st = FS_PTR;
                end
            end
            FS_PTR: begin
                d.addr = q.base + (q.bank ? UHP_DOFS_PCK1 : UHP_DOFS_PCK0);
                d.rd = 1'b1;
                d.st = FS_PCK;
            end
            FS_PCK: begin
                d.ptr = ram_rdata;
                d.st = FS_FIN;
            end
            FS_FIN: begin
                d.pck = ram_rdata;
                d.sz = sz_dec(ram_rdata[UHP_F_SIZE_HI:UHP_F_SIZE_LO]);
                d.done = 1'b1;
                d.mis = |(q.ptr & UHP_ALIGN_MASK);
                d.st = FS_IDLE;
            end
            default: begin
                d.st = FS_IDLE;
            end
        endcase
    end
    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign ram_addr = q.addr;
    assign ram_rd = q.rd;
    assign buf_ptr = q.ptr;
    assign pck_word = q.pck;
    assign size_bytes = q.sz;
    assign done = q.done;
    assign misaligned = q.mis;
    // ****************************************
    // Checks
    // ****************************************
    a_ptr_addr: assert property (@(posedge clk) disable iff (!nrst)
        (q.st == FS_PTR) |-> q.rd && q.addr == q.base + (q.bank ? UHP_DOFS_PTR1 : UHP_DOFS_PTR0))
        else $error("pointer fetch address wrong");
    a_pck_addr: assert property (@(posedge clk) disable iff (!nrst)
        (q.st == FS_PTR) |=> q.rd && q.addr == q.base + (q.bank ? UHP_DOFS_PCK1 : UHP_DOFS_PCK0)
        ##1 !q.rd ##1 q.done)
        else $error("size word fetch address wrong");
    a_size_code: assert property (@(posedge clk) disable iff (!nrst)
        q.done |-> q.sz == sz_dec(q.pck[UHP_F_SIZE_HI:UHP_F_SIZE_LO]) && q.sz != 11'h000)
        else $error("pipe size decode wrong");
endmodule // uhp_desc_fetch
`default_nettype wire

// >>> rtl/uhp_top.sv
// Host pipe interrupt enable and descriptor fetch, top level
`timescale 1ns/1ps
`default_nettype none
module uhp_top
    import uhp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic usb_reset,
    input wire logic pipe_enable_bit,
    input wire logic [7:0] pipe_flag,
    input wire logic pipe_is_out,
    output logic [31:0] ram_addr,
    output logic ram_rd,
    input wire logic [31:0] ram_rdata,
    output logic pipe_irq,
    output logic irq,
    output logic zlp_hw_handshake
);
    // ****************************************
    // State of the block
    // ****************************************
    typedef struct packed {
        logic [7:0] en;           // Shared enable state
        logic [UHP_EV_W-1:0] evt; // Sticky event status
        logic [UHP_EV_W-1:0] msk; // Event mask
        logic [31:0] base;        // Descriptor base address
        logic bank;               // Bank to fetch
        logic go;                 // Fetch start pulse
        logic [31:0] rdata;       // Read data, one cycle
        logic pirq;               // Pipe request
        logic irq;                // Event interrupt
        logic zlp;                // Hardware ZLP handshake
    } uhp_state_t;
    uhp_state_t q, d;
    // ****************************************
    // Fetcher connection
    // ****************************************
    logic [31:0] f_ptr;  // Fetched buffer pointer
    logic [31:0] f_pck;  // Fetched packet size word
    logic [10:0] f_size; // Decoded pipe size
    logic f_done;        // Fetch finished
    logic f_mis;         // Pointer not word aligned
    // ****************************************
    // Decoded strobes
    // ****************************************
    logic wr_clr; // Write to enable clear view
    logic wr_set; // Write to enable set view
    logic wr_evt; // Write to event status
    logic wr_msk; // Write to event mask
    logic wr_base; // Write to descriptor base
    logic wr_fetch; // Write to fetch control
    logic en_hold; // Pipe up and no USB reset
    logic [7:0] wbits; // Enable bits of write data
    logic [UHP_EV_W-1:0] ev_in; // Events this cycle
    logic [UHP_EV_W-1:0] ev_clr; // Write one to clear
    // Address decode for writes
    always_comb begin
        wr_clr = reg_wr && (reg_addr == UHP_ADR_EN_CLR);
        wr_set = reg_wr && (reg_addr == UHP_ADR_EN_SET);
        wr_evt = reg_wr && (reg_addr == UHP_ADR_EVT);
        wr_msk = reg_wr && (reg_addr == UHP_ADR_MASK);
        wr_base = reg_wr && (reg_addr == UHP_ADR_BASE);
        wr_fetch = reg_wr && (reg_addr == UHP_ADR_FETCH);
        en_hold = pipe_enable_bit && !usb_reset;
        // Unused positions are masked so they always read zero
        wbits = reg_wdata[7:0] & UHP_EN_MASK;
        ev_in = '0;
        ev_in[UHP_EV_DONE] = f_done;
        ev_in[UHP_EV_ALIGN] = f_mis;
        ev_clr = wr_evt ? reg_wdata[UHP_EV_W-1:0] : '0;
    end
    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        d.go = 1'b0;
        // Read data stand for one cycle only
        d.rdata = '0;
        // One state behind both views, so each sees the other's writes
        if (wr_clr) begin
            d.en = q.en & ~wbits;
        end
        if (wr_set) begin
            d.en = q.en | wbits;
        end
        // Disable wins over any write in the same cycle
        if (!en_hold) begin
            d.en = UHP_EN_RST;
        end
        // Set wins over clear, so no event is lost
        d.evt = (q.evt & ~ev_clr) | ev_in;
        if (wr_msk) begin
            d.msk = reg_wdata[UHP_EV_W-1:0];
        end
        if (wr_base) begin
            d.base = reg_wdata;
        end
        if (wr_fetch) begin
            d.bank = reg_wdata[0];
            d.go = 1'b1;
        end
        // Register read mux
        if (reg_rd) begin
            case (reg_addr)
                UHP_ADR_EN_CLR: begin
                    d.rdata = {24'h000000, q.en};
                end
                UHP_ADR_EN_SET: begin
                    d.rdata = {24'h000000, q.en};
                end
                UHP_ADR_BASE: begin
                    d.rdata = q.base;
                end
                UHP_ADR_FETCH: begin
                    d.rdata = {31'h00000000, q.bank};
                end
                UHP_ADR_PTR: begin
                    d.rdata = f_ptr;
                end
                UHP_ADR_PCK: begin
                    d.rdata = f_pck;
                end
                UHP_ADR_SIZE: begin
                    d.rdata = {21'h000000, f_size};
                end
                UHP_ADR_EVT: begin
                    d.rdata = {30'h00000000, q.evt};
                end
                UHP_ADR_MASK: begin
                    d.rdata = {30'h00000000, q.msk};
                end
                default: begin
                    // Unmapped addresses read zero
                    d.rdata = '0;
                end
            endcase
        end
        // Pipe request from current flags and enables
        d.pirq = |(pipe_flag & q.en & UHP_EN_MASK);
        // Level interrupt follows the new status and mask
        d.irq = |(d.evt & d.msk);
        // Only OUT pipes let hardware answer the zero length packet
        d.zlp = f_pck[UHP_F_AZLP] && pipe_is_out;
    end
    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    // ****************************************
    // Descriptor fetcher
    // ****************************************
    // Alignment is the software's duty; a bad pointer only raises an event
    uhp_desc_fetch u_fetch (
        .clk(clk),
        .nrst(nrst),
        .go(q.go),
        .bank(q.bank),
        .base(q.base),
        .ram_addr(ram_addr),
        .ram_rd(ram_rd),
        .ram_rdata(ram_rdata),
        .buf_ptr(f_ptr),
        .pck_word(f_pck),
        .size_bytes(f_size),
        .done(f_done),
        .misaligned(f_mis)
    );
    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata = q.rdata;
    assign pipe_irq = q.pirq;
    assign irq = q.irq;
    assign zlp_hw_handshake = q.zlp;
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_clr_pipe_error: assert property (
        wr_clr && reg_wdata[UHP_B_PIPE_ERROR] |=> !q.en[UHP_B_PIPE_ERROR]
        ##1 (!q.pirq || |$past(pipe_flag & q.en & UHP_EN_MASK)))
        else $error("pipe error enable not cleared");
    a_clr_transfer_fail: assert property (
        wr_clr && reg_wdata[UHP_B_TRANSFER_FAIL] |=> !q.en[UHP_B_TRANSFER_FAIL])
        else $error("transfer fail enable not cleared");
    a_clr_transfer_complete: assert property (
        wr_clr && reg_wdata[UHP_B_TRANSFER_COMPLETE] |=> !q.en[UHP_B_TRANSFER_COMPLETE])
        else $error("transfer complete enable not cleared");
    a_zero_keeps: assert property (
        (wr_clr || wr_set) && wbits == 8'h00 && en_hold |=> $stable(q.en))
        else $error("zero write changed enables");
    a_pipe_error_irq: assert property (
        pipe_flag[UHP_B_PIPE_ERROR] && q.en[UHP_B_PIPE_ERROR] |=> q.pirq)
        else $error("pipe error request missing");
    a_transfer_fail_irq: assert property (
        pipe_flag[UHP_B_TRANSFER_FAIL] && q.en[UHP_B_TRANSFER_FAIL] |=> q.pirq)
        else $error("transfer fail request missing");
    a_transfer_complete_irq: assert property (
        pipe_flag[UHP_B_TRANSFER_COMPLETE] && q.en[UHP_B_TRANSFER_COMPLETE] |=> q.pirq)
        else $error("transfer complete request missing");
    a_set_stall: assert property (
        wr_set && en_hold && reg_wdata[UHP_B_STALL] && reg_wdata[UHP_B_SETUP]
        |=> q.en[UHP_B_STALL] && q.en[UHP_B_SETUP])
        else $error("stall or setup enable not set");
    a_set_pipe_error: assert property (
        wr_set && en_hold && reg_wdata[UHP_B_PIPE_ERROR] |=> q.en[UHP_B_PIPE_ERROR])
        else $error("pipe error enable not set");
    a_views_match: assert property (
        reg_rd && (reg_addr == UHP_ADR_EN_CLR || reg_addr == UHP_ADR_EN_SET)
        |=> q.rdata[7:0] == $past(q.en) && q.rdata[31:8] == 24'h000000)
        else $error("enable view read mismatch");
    a_off_clears: assert property (
        !en_hold |=> q.en == UHP_EN_RST)
        else $error("enables not cleared on reset or disable");
    a_zlp_follow: assert property (
        ##1 q.zlp == $past(f_pck[UHP_F_AZLP] && pipe_is_out))
        else $error("zlp handshake mode wrong");
    a_or_request: assert property (
        ##1 q.pirq == $past(|(pipe_flag & q.en & UHP_EN_MASK)))
        else $error("pipe request not the OR of flag and enable");
    a_off_write: assert property (
        (wr_set || wr_clr) && !pipe_enable_bit |=> q.en == UHP_EN_RST ##1 q.en == UHP_EN_RST
        || $past(en_hold))
        else $error("write while disabled changed enables");
    a_evt_sticky: assert property (
        f_done && wr_evt && reg_wdata[UHP_EV_DONE] |=> q.evt[UHP_EV_DONE])
        else $error("event lost against clear");
endmodule // uhp_top
`default_nettype wire

// >>> tb/uhp_top_tb.sv
// Self-checking bench for the host pipe interrupt enable and descriptor fetch block
`timescale 1ns/1ps
`default_nettype none
module uhp_top_tb
    import uhp_pkg::*;
;
    // ****************************************
    // Signals and bench state
    // ****************************************
    logic clk, nrst, reg_wr, reg_rd, usb_reset, pipe_enable_bit, pipe_is_out;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, ram_addr, ram_rdata;
    logic ram_rd, pipe_irq, irq, zlp_hw_handshake;
    logic [7:0] pipe_flag;
    logic [7:0] en_m; // Expected enable state
    logic [31:0] base_v, ptr_v, pck_v, rd_v, rnd;
    logic [31:0] addr_q[$]; // RAM addresses seen
    int failures, n_compared;
    int bit_tab[5] = '{0, 2, 3, 4, 5}; // Enable positions

    uhp_top u_uhp_top (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_reset(usb_reset),
        .pipe_enable_bit(pipe_enable_bit), .pipe_flag(pipe_flag), .pipe_is_out(pipe_is_out),
        .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_rdata(ram_rdata), .pipe_irq(pipe_irq),
        .irq(irq), .zlp_hw_handshake(zlp_hw_handshake));

    // ****************************************
    // Clock and pipe RAM stand-in
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Answers the cycle after a read strobe; otherwise scrambles so stale data never passes
    always @(posedge clk) begin
        if (ram_rd === 1'b1) begin
            addr_q.push_back(ram_addr);
            ram_rdata <= (ram_addr[2] === 1'b0) ? ptr_v : pck_v;
        end else begin
            ram_rdata <= ~ram_rdata;
        end
    end

    // ****************************************
    // Expectation helpers and bus tasks
    // ****************************************
    function automatic logic [10:0] size_of(input logic [2:0] code);
        return (code == 3'h7) ? 11'h3ff : (11'h008 << code); // Full speed top code
    endfunction

    function automatic logic irq_of(input logic [7:0] fl, input logic [7:0] en);
        return |(fl & en & 8'h3d);
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write; the strobe drops at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle read; data stands only in the following cycle
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic close_out;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch
    initial begin
        #(100 * 20000);
        failures++;
        close_out();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        usb_reset = 1'b0;
        pipe_enable_bit = 1'b1;
        pipe_flag = 8'h00;
        pipe_is_out = 1'b0;
        ram_rdata = 32'h0;
        ptr_v = 32'h0;
        pck_v = 32'h0;
        failures = 0;
        n_compared = 0;
        void'($urandom(6612));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        // Reset state of both views, and an unmapped place
        rd(UHP_ADR_EN_SET, rd_v);
        chk("enable set view", rd_v, 32'h0);
        rd(UHP_ADR_EN_CLR, rd_v);
        chk("enable clear view", rd_v, 32'h0);
        rd(12'hffc, rd_v);
        chk("unmapped read", rd_v, 32'h0);
        // Each source alone: clear it, flag it, set it again
        for (int k = 0; k < 5; k++) begin
            wr(UHP_ADR_EN_SET, 32'hff); // Reserved bits must read zero
            wr(UHP_ADR_EN_CLR, 32'h1 << bit_tab[k]);
            pipe_flag <= 8'h1 << bit_tab[k];
            rd(UHP_ADR_EN_SET, rd_v);
            chk("enable after clear", rd_v, 32'h3d & ~(32'h1 << bit_tab[k]));
            chk("request with enable off", pipe_irq, 32'h0);
            wr(UHP_ADR_EN_SET, 32'h1 << bit_tab[k]);
            rd(UHP_ADR_EN_CLR, rd_v);
            chk("enable after set", rd_v, 32'h3d);
            chk("request with enable on", pipe_irq, 32'h1);
        end
        // Random mix of set and clear writes, read through either view
        en_m = 8'h3d;
        for (int n = 0; n < 40; n++) begin
            rnd = $urandom;
            pipe_flag <= rnd[15:8];
            if (rnd[16]) begin
                wr(UHP_ADR_EN_SET, {24'h0, rnd[7:0]});
                en_m = en_m | (rnd[7:0] & 8'h3d);
            end else begin
                wr(UHP_ADR_EN_CLR, {24'h0, rnd[7:0]});
                en_m = en_m & ~rnd[7:0];
            end
            rd(rnd[17] ? UHP_ADR_EN_SET : UHP_ADR_EN_CLR, rd_v);
            chk("enable state", rd_v, {24'h0, en_m});
            chk("pipe request", pipe_irq, irq_of(rnd[15:8], en_m));
        end
        // Pipe disabled, then USB reset: enables stay zero even when written
        pipe_flag <= 8'hff;
        wr(UHP_ADR_EN_SET, 32'h3d);
        pipe_enable_bit <= 1'b0;
        wr(UHP_ADR_EN_SET, 32'h3d);
        rd(UHP_ADR_EN_CLR, rd_v);
        chk("enable with pipe off", rd_v, 32'h0);
        chk("request with pipe off", pipe_irq, 32'h0);
        pipe_enable_bit <= 1'b1;
        wr(UHP_ADR_EN_SET, 32'h3d);
        usb_reset <= 1'b1;
        wr(UHP_ADR_EN_SET, 32'h14);
        usb_reset <= 1'b0;
        rd(UHP_ADR_EN_SET, rd_v);
        chk("enable after usb reset", rd_v, 32'h0);
        // Descriptor fetch for both banks and every size code
        for (int i = 0; i < 8; i++) begin
            rnd = $urandom;
            base_v = $urandom & 32'hffffffe0;
            ptr_v = ($urandom & 32'hfffffffc) | ((i == 5) ? 32'h1 : 32'h0);
            pck_v = {rnd[31], i[2:0], rnd[27:0]};
            pipe_is_out <= i[1];
            addr_q.delete();
            wr(UHP_ADR_MASK, (i == 0) ? 32'h0 : 32'h3); // First pass masked off
            wr(UHP_ADR_BASE, base_v);
            wr(UHP_ADR_FETCH, {31'h0, i[0]});
            repeat (6) @(posedge clk);
            #1;
            chk("fetch count", addr_q.size(), 32'h2);
            chk("pointer address", addr_q[0], base_v + (i[0] ? 32'h10 : 32'h0));
            chk("size address", addr_q[1], base_v + (i[0] ? 32'h14 : 32'h4));
            chk("event interrupt", irq, (i != 0) ? 32'h1 : 32'h0);
            chk("zlp by hardware", zlp_hw_handshake, pck_v[31] & i[1]);
            rd(UHP_ADR_PTR, rd_v);
            chk("buffer pointer", rd_v, ptr_v);
            rd(UHP_ADR_PCK, rd_v);
            chk("size word", rd_v, pck_v);
            rd(UHP_ADR_SIZE, rd_v);
            chk("pipe size", rd_v, size_of(i[2:0]));
            rd(UHP_ADR_EVT, rd_v);
            chk("event status", rd_v, {30'h0, (i == 5), 1'b1});
            wr(UHP_ADR_EVT, 32'h3);
            rd(UHP_ADR_EVT, rd_v);
            chk("event cleared", rd_v, 32'h0);
            chk("interrupt cleared", irq, 32'h0);
        end
        close_out();
    end
endmodule // uhp_top_tb
`default_nettype wire
